// *** logic/bio_pkg.sv ***
// Constants, reset values and state codes shared by the I/O port design
package bio_pkg;

	// ----------------------------------------------------------------
	// Port widths
	// ----------------------------------------------------------------
	localparam int FIRST_WIDTH  = 8;
	localparam int SECOND_WIDTH = 3;
	localparam int BUS_WIDTH    = 8;

	// ----------------------------------------------------------------
	// Data-memory addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FIRST_DATA  = 8'h12;
	localparam logic [7:0] ADDR_FIRST_DIR   = 8'h13;
	localparam logic [7:0] ADDR_SECOND_DATA = 8'h14;
	localparam logic [7:0] ADDR_SECOND_DIR  = 8'h15;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_FIRST_DATA  = 8'hFF;
	localparam logic [7:0] RST_FIRST_DIR   = 8'hFF;
	localparam logic [2:0] RST_SECOND_DATA = 3'h7;
	localparam logic [2:0] RST_SECOND_DIR  = 3'h7;
	localparam logic [7:0] RST_READ_DATA   = 8'h00;

	// ----------------------------------------------------------------
	// Wake-up timing
	// ----------------------------------------------------------------
	localparam int WAKE_DELAY_TSYS  = 1024;
	localparam int REF_PER_TSYS     = 1;
	localparam int WAKE_DELAY_CYC   = WAKE_DELAY_TSYS * REF_PER_TSYS;

	// ----------------------------------------------------------------
	// Halt and wake sequencing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BIO_RUN   = 2'b00,
		BIO_WATCH = 2'b01,
		BIO_WAIT  = 2'b10
	} bio_wake_t;

endpackage

// *** logic/bio_wake_timer.sv ***
// Start-up delay counter used after a wake-up from halt
`timescale 1ns/1ns
module bio_wake_timer
	import bio_pkg::*;
#(
	parameter int DELAY_CYC = WAKE_DELAY_CYC
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam int CW = (DELAY_CYC > 1) ? $clog2(DELAY_CYC) : 1;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (DELAY_CYC < 1) begin : gBadDelay
			$error("bio_wake_timer: DELAY_CYC must be at least one");
		end
	endgenerate

	logic [CW-1:0] count_r;
	logic          busy_r;
	logic          done_r;
	wire  logic    lastCycle = busy_r && (count_r == '0);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_r <= '0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			done_r <= lastCycle;
			if (start && !busy_r) begin
				count_r <= CW'(DELAY_CYC - 1);
				busy_r  <= 1'b1;
			end else if (lastCycle) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				count_r <= count_r - CW'(1);
			end
		end
	end

	assign busy = busy_r;
	assign done = done_r;

endmodule // bio_wake_timer

// *** logic/bio_ports.sv ***
// Two memory-mapped bidirectional I/O ports with halt wake-up
//
// Behaviour
// - Eleven bidirectional lines: eight-line first port, three-line second port.
// - First port latch decoded at 12H, second port latch at 14H.
// - Direction registers decoded at 13H and 15H.
// - Read data is registered and held; pads sampled on the clock edge with the read strobe high.
// - Output latch holds its value until software writes it again.
// - Per-line direction bit; 1 makes input, 0 enables push-pull driver.
// - Read returns pad when direction is 1, latch when 0.
// - Output lines always driven high and low; no open drain.
// - After reset every line is an input.
// - Bit set, clear, complement read whole port then write back.
// - Upper five second-port bits read zero, writes ignored.
// - Each first-port line can wake from halt, enabled per line.
// - Pull-high resistors are a build option; absent means floating input.
// - After a wake event wait 1024 system clocks before resuming.
// - Port wake resumes at the next instruction, no reset.
`timescale 1ns/1ns
module bio_ports
	import bio_pkg::*;
#(
	parameter logic [FIRST_WIDTH-1:0] WAKE_ENABLE   = 8'hFF,
	parameter logic                   PULL_HIGH_OPT = 1'b1,
	parameter int                     WAKE_DELAY    = WAKE_DELAY_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic [7:0]              memAddr,
	input  wire logic                    memWrEn,
	input  wire logic [BUS_WIDTH-1:0]    memWrData,
	input  wire logic                    memRdEn,
	output logic      [BUS_WIDTH-1:0]    memRdData,
	input  wire logic [FIRST_WIDTH-1:0]  firstPortPadIn,
	output logic      [FIRST_WIDTH-1:0]  firstPortPadOut,
	output logic      [FIRST_WIDTH-1:0]  firstPortPadOe,
	output logic      [FIRST_WIDTH-1:0]  firstPortPullEn,
	input  wire logic [SECOND_WIDTH-1:0] secondPortPadIn,
	output logic      [SECOND_WIDTH-1:0] secondPortPadOut,
	output logic      [SECOND_WIDTH-1:0] secondPortPadOe,
	output logic      [SECOND_WIDTH-1:0] secondPortPullEn,
	input  wire logic                    cpuHalted,
	output logic                         wakeRequest,
	output logic                         resumePulse
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (WAKE_DELAY < 1) begin : gBadWake
			$error("bio_ports: WAKE_DELAY must be at least one");
		end
		if (FIRST_WIDTH + SECOND_WIDTH != 11) begin : gBadWidth
			$error("bio_ports: port widths must total eleven lines");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [FIRST_WIDTH-1:0]  firstData_r;
	logic [FIRST_WIDTH-1:0]  firstDir_r;
	logic [SECOND_WIDTH-1:0] secondData_r;
	logic [SECOND_WIDTH-1:0] secondDir_r;
	logic [FIRST_WIDTH-1:0]  firstOe_r;
	logic [SECOND_WIDTH-1:0] secondOe_r;
	logic [FIRST_WIDTH-1:0]  firstPull_r;
	logic [SECOND_WIDTH-1:0] secondPull_r;
	logic [BUS_WIDTH-1:0]    rdData_r;
	logic [FIRST_WIDTH-1:0]  padPrev_r;
	logic                    wakeReq_r;
	bio_wake_t               wakeState_r;
	bio_wake_t               wakeState_nxt;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Data latch and direction register decode
	wire logic selFirstData  = (memAddr == ADDR_FIRST_DATA);
	wire logic selSecondData = (memAddr == ADDR_SECOND_DATA);
	wire logic selFirstDir   = (memAddr == ADDR_FIRST_DIR);
	wire logic selSecondDir  = (memAddr == ADDR_SECOND_DIR);

	wire logic wrFirstData   = memWrEn && selFirstData;
	wire logic wrFirstDir    = memWrEn && selFirstDir;
	wire logic wrSecondData  = memWrEn && selSecondData;
	wire logic wrSecondDir   = memWrEn && selSecondDir;

	// ----------------------------------------------------------------
	// Next register values
	// ----------------------------------------------------------------
	// Latch holds until rewritten
	wire logic [FIRST_WIDTH-1:0] firstData_nxt =
		wrFirstData ? memWrData[FIRST_WIDTH-1:0] : firstData_r;
	wire logic [SECOND_WIDTH-1:0] secondData_nxt =
		wrSecondData ? memWrData[SECOND_WIDTH-1:0] : secondData_r;
	wire logic [FIRST_WIDTH-1:0] firstDir_nxt =
		wrFirstDir ? memWrData[FIRST_WIDTH-1:0] : firstDir_r;
	wire logic [SECOND_WIDTH-1:0] secondDir_nxt =
		wrSecondDir ? memWrData[SECOND_WIDTH-1:0] : secondDir_r;

	// ----------------------------------------------------------------
	// Read source per line
	// ----------------------------------------------------------------
	logic [FIRST_WIDTH-1:0]  firstRead;
	logic [SECOND_WIDTH-1:0] secondRead;

	genvar gi;
	generate
		for (gi = 0; gi < FIRST_WIDTH; gi++) begin : gFirstRd
			assign firstRead[gi] = firstDir_r[gi] ? firstPortPadIn[gi] : firstData_r[gi];
		end
		for (gi = 0; gi < SECOND_WIDTH; gi++) begin : gSecondRd
			assign secondRead[gi] = secondDir_r[gi] ? secondPortPadIn[gi] : secondData_r[gi];
		end
	endgenerate

	localparam int SECOND_PAD = BUS_WIDTH - SECOND_WIDTH;
	wire logic [BUS_WIDTH-1:0] secondReadWord = {{SECOND_PAD{1'b0}}, secondRead};
	wire logic [BUS_WIDTH-1:0] secondDirWord  = {{SECOND_PAD{1'b0}}, secondDir_r};

	wire logic [BUS_WIDTH-1:0] readMux =
		selFirstData  ? firstRead      :
		selFirstDir   ? firstDir_r     :
		selSecondData ? secondReadWord :
		selSecondDir  ? secondDirWord  :
		RST_READ_DATA;

	// ----------------------------------------------------------------
	// Port registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstData_r  <= RST_FIRST_DATA;
			secondData_r <= RST_SECOND_DATA;
		end else begin
			firstData_r  <= firstData_nxt;
			secondData_r <= secondData_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstDir_r  <= RST_FIRST_DIR;
			secondDir_r <= RST_SECOND_DIR;
		end else begin
			firstDir_r  <= firstDir_nxt;
			secondDir_r <= secondDir_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pad drivers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstOe_r  <= ~RST_FIRST_DIR;
			secondOe_r <= ~RST_SECOND_DIR;
		end else begin
			firstOe_r  <= ~firstDir_nxt;
			secondOe_r <= ~secondDir_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstPull_r  <= {FIRST_WIDTH{PULL_HIGH_OPT}} & RST_FIRST_DIR;
			secondPull_r <= {SECOND_WIDTH{PULL_HIGH_OPT}} & RST_SECOND_DIR;
		end else begin
			firstPull_r  <= {FIRST_WIDTH{PULL_HIGH_OPT}} & firstDir_nxt;
			secondPull_r <= {SECOND_WIDTH{PULL_HIGH_OPT}} & secondDir_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdData_r <= RST_READ_DATA;
		end else if (memRdEn) begin
			rdData_r <= readMux;
		end
	end

	// ----------------------------------------------------------------
	// Wake edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			padPrev_r <= RST_FIRST_DATA;
		end else begin
			padPrev_r <= firstPortPadIn;
		end
	end

	logic [FIRST_WIDTH-1:0] lineFall;
	generate
		for (gi = 0; gi < FIRST_WIDTH; gi++) begin : gWake
			assign lineFall[gi] = WAKE_ENABLE[gi] && firstDir_r[gi]
				&& padPrev_r[gi] && !firstPortPadIn[gi];
		end
	endgenerate

	wire logic wakeEvent = cpuHalted && (|lineFall);

	// ----------------------------------------------------------------
	// Halt and wake sequencing
	// ----------------------------------------------------------------
	logic timerBusy;
	logic timerDone;
	wire  logic timerStart = (wakeState_r == BIO_WATCH) && wakeEvent && !timerBusy;

	always_comb begin
		wakeState_nxt = wakeState_r;
		unique case (wakeState_r)
			BIO_RUN: begin
				if (cpuHalted) begin
					wakeState_nxt = BIO_WATCH;
				end
			end
			BIO_WATCH: begin
				if (wakeEvent) begin
					wakeState_nxt = BIO_WAIT;
				end else if (!cpuHalted) begin
					wakeState_nxt = BIO_RUN;
				end
			end
			BIO_WAIT: begin
				if (timerDone) begin
					wakeState_nxt = BIO_RUN;
				end
			end
			default: begin
				wakeState_nxt = BIO_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wakeState_r <= BIO_RUN;
		end else begin
			wakeState_r <= wakeState_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wakeReq_r <= 1'b0;
		end else if (timerStart) begin
			wakeReq_r <= 1'b1;
		end else if (wakeState_r == BIO_WAIT && timerDone) begin
			wakeReq_r <= 1'b0;
		end
	end

	bio_wake_timer #(
		.DELAY_CYC (WAKE_DELAY)
	) uWakeTimer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.start   (timerStart),
		.busy    (timerBusy),
		.done    (timerDone)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Eleven lines driven
	assign firstPortPadOut  = firstData_r;
	assign firstPortPadOe   = firstOe_r;
	assign firstPortPullEn  = firstPull_r;
	assign secondPortPadOut = secondData_r;
	assign secondPortPadOe  = secondOe_r;
	assign secondPortPullEn = secondPull_r;
	assign memRdData        = rdData_r;
	assign wakeRequest      = wakeReq_r;
	assign resumePulse      = timerDone;

endmodule // bio_ports

// *** sim/bio_ports_monitor.sv ***
// Checker of register and wake behaviour at the I/O port boundary
`timescale 1ns/1ns
module bio_ports_monitor
	import bio_pkg::*;
#(
	parameter logic PULL_HIGH_OPT = 1'b1,
	parameter int   WAKE_DELAY    = WAKE_DELAY_CYC
) (
	input wire logic                    ref_clk,
	input wire logic                    nrst,
	input wire logic [7:0]              memAddr,
	input wire logic                    memWrEn,
	input wire logic [BUS_WIDTH-1:0]    memWrData,
	input wire logic                    memRdEn,
	input wire logic [BUS_WIDTH-1:0]    memRdData,
	input wire logic [FIRST_WIDTH-1:0]  firstPortPadIn,
	input wire logic [FIRST_WIDTH-1:0]  firstPortPadOut,
	input wire logic [FIRST_WIDTH-1:0]  firstPortPadOe,
	input wire logic [FIRST_WIDTH-1:0]  firstPortPullEn,
	input wire logic [SECOND_WIDTH-1:0] secondPortPadOe,
	input wire logic                    cpuHalted,
	input wire logic                    wakeRequest,
	input wire logic                    resumePulse
);
	// ----------------------------------------------------------------
	// Decodes and properties
	// ----------------------------------------------------------------
	wire wrFirst  = memWrEn && memAddr == ADDR_FIRST_DATA;
	wire wrDir1   = memWrEn && memAddr == ADDR_FIRST_DIR;
	wire wrDir2   = memWrEn && memAddr == ADDR_SECOND_DIR;
	wire rdFirst  = memRdEn && memAddr == ADDR_FIRST_DATA;
	wire rdSecond = memRdEn && (memAddr == ADDR_SECOND_DATA || memAddr == ADDR_SECOND_DIR);
	// Cycles since wake request rose
	int wakeAge_r;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wakeAge_r <= 0;
		end else if (!wakeRequest) begin
			wakeAge_r <= 0;
		end else begin
			wakeAge_r <= wakeAge_r + 1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	first_latch_a: assert property (wrFirst |=> firstPortPadOut == $past(memWrData))
		else $error("first latch write not applied");
	latch_hold_a: assert property (!wrFirst |=> $stable(firstPortPadOut))
		else $error("first latch changed without write");
	first_dir_a: assert property (wrDir1 |=> firstPortPadOe == ~$past(memWrData))
		else $error("first direction write wrong");
	second_dir_a: assert property (wrDir2 |=> secondPortPadOe == ~$past(memWrData[2:0]))
		else $error("second direction write wrong");
	read_mux_a: assert property (rdFirst |=> memRdData ==
		$past((firstPortPadIn & ~firstPortPadOe) | (firstPortPadOut & firstPortPadOe)))
		else $error("first port read mux wrong");
	upper_zero_a: assert property (rdSecond |=> memRdData[7:3] == 5'h00)
		else $error("second port upper bits not zero");
	read_hold_a: assert property (!memRdEn |=> $stable(memRdData))
		else $error("read data changed without strobe");
	pull_follow_a: assert property (firstPortPullEn == (~firstPortPadOe & {8{PULL_HIGH_OPT}}))
		else $error("pull enable wrong");
	wake_delay_a: assert property (resumePulse == (wakeRequest && wakeAge_r == WAKE_DELAY))
		else $error("resume pulse not at wake delay");
	resume_end_a: assert property (resumePulse |=> !resumePulse && !wakeRequest)
		else $error("resume not a single cycle");
	run_no_wake_a: assert property (!cpuHalted && !wakeRequest |=> !wakeRequest)
		else $error("wake raised while running");
	cover property (wrFirst);
	cover property ($rose(wakeRequest));
	cover property (rdFirst && firstPortPadOe != 8'h00 && firstPortPadOe != 8'hFF);
endmodule // bio_ports_monitor

bind bio_ports bio_ports_monitor #(.PULL_HIGH_OPT(PULL_HIGH_OPT), .WAKE_DELAY(WAKE_DELAY)) mon (
	.ref_clk(ref_clk), .nrst(nrst), .memAddr(memAddr), .memWrEn(memWrEn), .memWrData(memWrData),
	.memRdEn(memRdEn), .memRdData(memRdData), .firstPortPadIn(firstPortPadIn),
	.firstPortPadOut(firstPortPadOut), .firstPortPadOe(firstPortPadOe), .firstPortPullEn(firstPortPullEn),
	.secondPortPadOe(secondPortPadOe), .cpuHalted(cpuHalted), .wakeRequest(wakeRequest),
	.resumePulse(resumePulse));

// *** sim/bio_pad_model.sv ***
// Board-side pad model: resolves each pin from chip driver, external source and pull-high
`timescale 1ns/1ns
module bio_pad_model #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic [W-1:0] padOut,
	input  wire logic [W-1:0] padOe,
	input  wire logic [W-1:0] pullEn,
	input  wire logic [W-1:0] extVal,
	input  wire logic [W-1:0] extEn,
	output logic      [W-1:0] padIn
);
	logic [W-1:0] floatPat = '0;
	// Floating line changes every cycle
	always @(posedge ref_clk) floatPat <= ~floatPat;
	always_comb begin
		for (int i = 0; i < W; i++)
			padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extVal[i] : pullEn[i] ? 1'b1 : floatPat[i];
	end
endmodule // bio_pad_model

// *** sim/tb_top.sv ***
// Top-level bench: register, direction and wake-up scenarios for the I/O ports
`timescale 1ns/1ns
module tb_top;
	import bio_pkg::*;
	localparam int DLY = 8;
	logic       ref_clk, nrst, memWrEn, memRdEn, cpuHalted, wakeRequest, resumePulse;
	logic [7:0] memAddr, memWrData, memRdData, p1In, p1Out, p1Oe, p1Pull, ext1, ext1En, rd;
	logic [2:0] p2In, p2Out, p2Oe, p2Pull, ext2, ext2En;
	int         err_total, samples_checked, n;

	bio_ports #(.WAKE_ENABLE(8'hFE), .PULL_HIGH_OPT(1'b1), .WAKE_DELAY(DLY)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .memAddr(memAddr), .memWrEn(memWrEn), .memWrData(memWrData),
		.memRdEn(memRdEn), .memRdData(memRdData), .firstPortPadIn(p1In), .firstPortPadOut(p1Out),
		.firstPortPadOe(p1Oe), .firstPortPullEn(p1Pull), .secondPortPadIn(p2In), .secondPortPadOut(p2Out),
		.secondPortPadOe(p2Oe), .secondPortPullEn(p2Pull), .cpuHalted(cpuHalted),
		.wakeRequest(wakeRequest), .resumePulse(resumePulse));
	bio_pad_model #(.W(8)) pads1 (.ref_clk(ref_clk), .padOut(p1Out), .padOe(p1Oe), .pullEn(p1Pull),
		.extVal(ext1), .extEn(ext1En), .padIn(p1In));
	bio_pad_model #(.W(3)) pads2 (.ref_clk(ref_clk), .padOut(p2Out), .padOe(p2Oe), .pullEn(p2Pull),
		.extVal(ext2), .extEn(ext2En), .padIn(p2In));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		memAddr <= a;
		memWrData <= d;
		memWrEn <= 1'b1;
		@(posedge ref_clk);
		memWrEn <= 1'b0;
		#1;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		memAddr <= a;
		memRdEn <= 1'b1;
		@(posedge ref_clk);
		memRdEn <= 1'b0;
		#1 chk($sformatf("read %h", a), memRdData, exp);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		give_verdict();
	end

	initial begin
		{memAddr, memWrData, memWrEn, memRdEn, cpuHalted, nrst} = '0;
		{ext1, ext1En, ext2, ext2En} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		#1 chk("oe1", p1Oe, 8'h00);
		chk("pull1", p1Pull, 8'hFF);
		chk("oe2", {5'h00, p2Oe}, 8'h00);
		chk("pull2", {5'h00, p2Pull}, 8'h07);
		rdChk(ADDR_FIRST_DATA, 8'hFF);
		rdChk(ADDR_FIRST_DIR, 8'hFF);
		rdChk(ADDR_SECOND_DATA, 8'h07);
		rdChk(ADDR_SECOND_DIR, 8'h07);
		wr(ADDR_FIRST_DATA, 8'h5A);
		chk("out1", p1Out, 8'h5A);
		rdChk(ADDR_FIRST_DATA, 8'hFF);
		ext1 <= 8'h30;
		ext1En <= 8'hF0;
		wr(ADDR_FIRST_DIR, 8'hF0);
		chk("oe1", p1Oe, 8'h0F);
		chk("pull1", p1Pull, 8'hF0);
		rdChk(ADDR_FIRST_DATA, 8'h3A);
		wr(ADDR_FIRST_DATA, 8'h3A | 8'h80);
		chk("out1", p1Out, 8'hBA);
		wr(ADDR_SECOND_DATA, 8'hFF);
		wr(8'h16, 8'h00);
		chk("out1", p1Out, 8'hBA);
		rdChk(8'h16, 8'h00);
		wr(ADDR_SECOND_DIR, 8'hF8);
		chk("oe2", {5'h00, p2Oe}, 8'h07);
		chk("pull2", {5'h00, p2Pull}, 8'h00);
		rdChk(ADDR_SECOND_DIR, 8'h00);
		wr(ADDR_SECOND_DATA, 8'hFA);
		chk("out2", {5'h00, p2Out}, 8'h02);
		rdChk(ADDR_SECOND_DATA, 8'h02);
		ext1 <= 8'hFF;
		ext1En <= 8'hFF;
		wr(ADDR_FIRST_DIR, 8'hFF);
		cpuHalted <= 1'b1;
		repeat (3) @(posedge ref_clk);
		ext1 <= 8'hFE;
		repeat (4) @(posedge ref_clk);
		#1 chk("wake off", {7'h00, wakeRequest}, 8'h00);
		@(posedge ref_clk);
		ext1 <= 8'hF6;
		n = 0;
		while (wakeRequest !== 1'b1 && n < 5) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("wake", {7'h00, wakeRequest}, 8'h01);
		n = 0;
		while (resumePulse !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("delay", n[7:0], DLY[7:0]);
		@(posedge ref_clk);
		cpuHalted <= 1'b0;
		#1 chk("wake end", {6'h00, wakeRequest, resumePulse}, 8'h00);
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		#1 chk("oe1", p1Oe, 8'h00);
		rdChk(ADDR_FIRST_DIR, 8'hFF);
		rdChk(ADDR_FIRST_DATA, 8'hF6);
		give_verdict();
	end
endmodule // tb_top
